// >>> ras_ctrl_pkg.sv
// constants, field layouts and state codes for the memory reliability control block
package ras_ctrl_pkg;

	localparam int NID_W  = 6;
	localparam int RANK_W = 3;

	// register byte offsets
	localparam logic [7:0] OFF_MIRROR_CFG  = 8'h00;
	localparam logic [7:0] OFF_CHAN_CTL    = 8'h04;
	localparam logic [7:0] OFF_SPARE_CTL   = 8'h08;
	localparam logic [7:0] OFF_SCRUB_START = 8'h0C;
	localparam logic [7:0] OFF_SCRUB_END   = 8'h10;
	localparam logic [7:0] OFF_STATUS      = 8'h14;
	localparam logic [7:0] OFF_DIR_CFG     = 8'h18;
	localparam logic [7:0] OFF_INTERRUPTED = 8'h1C;

	// mirror config fields
	localparam int MIR_MODE_LSB = 0;
	localparam int MIR_TAE_BIT  = 2;
	localparam int MIR_RSPV_BIT = 3;
	localparam int MIR_DIR_BIT  = 4;
	localparam int MIR_TRK_LSB  = 5;
	localparam int MIR_NID_LSB  = 8;
	localparam logic [1:0] MODE_OFF     = 2'h0;
	localparam logic [1:0] MODE_MIGRATE = 2'h1;
	localparam logic [1:0] MODE_MIRROR  = 2'h2;

	// channel control fields
	localparam int CH_START_BIT = 0;
	localparam int CH_RESET_BIT = 1;
	localparam int CH_TRAIN_BIT = 2;

	// sparing control fields
	localparam int SP_MODE_LSB   = 0;
	localparam int SP_WPDIS_BIT  = 2;
	localparam int SP_PATROL_BIT = 3;
	localparam int SP_SMI_BIT    = 4;
	localparam int SP_FAIL_LSB   = 8;
	localparam int SP_SPARE_LSB  = 12;
	localparam logic [1:0] SPARE_OFF      = 2'h0;
	localparam logic [1:0] SPARE_COPY     = 2'h1;
	localparam logic [1:0] SPARE_REDIRECT = 2'h2;

	// status fields
	localparam int ST_DONE_BIT   = 0;
	localparam int ST_IDLE_BIT   = 1;
	localparam int ST_CONFL_BIT  = 2;
	localparam int ST_DIRERR_BIT = 3;
	localparam int ST_SNPDUP_BIT = 4;
	localparam int ST_PORT_LSB   = 8;

	// directory config fields
	localparam int DIR_IOEN_BIT   = 0;
	localparam int DIR_FANOUT_BIT = 1;
	localparam int DIR_AGENT_LSB  = 8;

	// node-ID bit that selects the hemisphere
	localparam int HEMI_BIT = 1;

	// virtual network code for mirror data
	localparam logic [1:0] VN_A1 = 2'h1;

	typedef enum logic [3:0] {
		PORT_READY    = 4'h1,
		PORT_ACTIVE   = 4'h2,
		PORT_DISABLED = 4'h4,
		PORT_TRAINING = 4'h8
	} port_state_t;

	typedef enum logic [2:0] {
		CP_IDLE = 3'h1,
		CP_COPY = 3'h2,
		CP_DONE = 3'h4
	} copy_state_t;

endpackage

// >>> ras_ctrl.sv
// memory reliability control: mirror setup, channel reset handshake, rank sparing engine
`timescale 1ns/1ps
`default_nettype none
module ras_ctrl
#(
	parameter int ADDR_W = 24
)
(
	input  wire logic                            clk_sys,
	input  wire logic                            nrst,
	// classic wishbone slave
	input  wire logic                            wb_cyc_i,
	input  wire logic                            wb_stb_i,
	input  wire logic                            wb_we_i,
	input  wire logic [7:0]                      wb_adr_i,
	input  wire logic [3:0]                      wb_sel_i,
	input  wire logic [31:0]                     wb_dat_i,
	output logic      [31:0]                     wb_dat_o,
	output logic                                 wb_ack_o,
	// mirror traffic steering
	output logic                                 mirror_en,
	output logic                                 mirror_is_slave,
	output logic                                 mirror_migrate,
	output logic      [ras_ctrl_pkg::NID_W-1:0]  mirror_dest_nid,
	output logic      [1:0]                      mirror_vn,
	// memory port (channel)
	input  wire logic                            phy_init_done,
	output logic                                 port_link_up,
	output logic                                 data_lane_idle,
	output logic                                 clk_lane_dc_high,
	output logic                                 phy_train_req,
	// controller policy
	output logic                                 write_post_en,
	output logic                                 patrol_en,
	input  wire logic                            scrub_idle,
	output logic                                 smi_req,
	// sparing copy port
	output logic                                 copy_req,
	output logic      [ras_ctrl_pkg::RANK_W-1:0] copy_src_rank,
	output logic      [ras_ctrl_pkg::RANK_W-1:0] copy_dst_rank,
	output logic      [ADDR_W-1:0]               copy_addr,
	input  wire logic                            copy_ack,
	// demand access remapping
	input  wire logic                            acc_valid,
	input  wire logic                            acc_write,
	input  wire logic [ras_ctrl_pkg::RANK_W-1:0] acc_rank,
	input  wire logic [ADDR_W-1:0]               acc_addr,
	output logic                                 acc_stall,
	output logic                                 acc_out_valid,
	output logic                                 acc_out_write,
	output logic      [ras_ctrl_pkg::RANK_W-1:0] acc_out_rank,
	output logic      [ADDR_W-1:0]               acc_out_addr,
	output logic                                 acc_out_dup,
	// snoop responses
	input  wire logic                            snp_txn_start,
	input  wire logic [ras_ctrl_pkg::NID_W-1:0]  snp_req_nid,
	input  wire logic                            snp_rsp_valid,
	input  wire logic [ras_ctrl_pkg::NID_W-1:0]  snp_rsp_nid,
	output logic                                 snp_rsp_accept
);
	import ras_ctrl_pkg::*;

	initial
	begin
		if (ADDR_W < 1 || ADDR_W > 32)
			$error("ADDR_W must be 1..32");
	end

	////////////////////////////////////////////////////////////////////////
	// register storage

	logic [1:0]        mir_mode_reg;
	logic              mir_tae_reg;
	logic              mir_rspv_reg;
	logic              mir_dir_reg;
	logic [1:0]        mir_trk_reg;
	logic [NID_W-1:0]  mir_nid_reg;
	logic              start_init_reg;
	logic [1:0]        spare_mode_reg;
	logic              wp_dis_reg;
	logic              patrol_reg;
	logic              smi_en_reg;
	logic [RANK_W-1:0] fail_rank_reg;
	logic [RANK_W-1:0] spare_rank_reg;
	logic [ADDR_W-1:0] scrub_start_reg;
	logic [ADDR_W-1:0] scrub_end_reg;
	logic              io_dir_reg;
	logic              fanout_reg;
	logic [NID_W-1:0]  dir_agent_reg;
	logic              done_reg;
	logic              snp_dup_reg;
	logic              ack_reg;
	logic [31:0]       rdata_reg;
	port_state_t       port_reg;
	copy_state_t       copy_reg;
	logic [ADDR_W-1:0] ptr_reg;
	logic [2:0]        sync_reg;
	logic              init_done_reg;
	logic              snp_seen_reg;

	logic wr_stb;
	logic rd_stb;
	logic conflict;
	logic dir_err;
	logic copy_last;
	logic copy_finish;

	// one request per two cycles, answered on the next edge
	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg && wb_sel_i[0];
	assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;

	// sparing is refused while mirroring, migration, posting or patrol is on
	assign conflict = (mir_mode_reg != MODE_OFF) || !wp_dis_reg || patrol_reg;
	assign dir_err  = io_dir_reg && (!fanout_reg || dir_agent_reg[0]);

	assign copy_last   = (ptr_reg == scrub_end_reg);
	assign copy_finish = (copy_reg == CP_COPY) && copy_ack && copy_last;

	////////////////////////////////////////////////////////////////////////
	// bus handshake: ack one cycle after the request, dropped the next
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			ack_reg <= 1'b0;
		else
			ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// configuration writes; byte lane 0 gates every write (fields fit in 16 bits or pointer)
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			mir_mode_reg    <= MODE_OFF;
			mir_tae_reg     <= 1'b0;
			mir_rspv_reg    <= 1'b0;
			mir_dir_reg     <= 1'b0;
			mir_trk_reg     <= 2'h0;
			mir_nid_reg     <= '0;
			start_init_reg  <= 1'b0;
			spare_mode_reg  <= SPARE_OFF;
			wp_dis_reg      <= 1'b0;
			patrol_reg      <= 1'b0;
			smi_en_reg      <= 1'b0;
			fail_rank_reg   <= '0;
			spare_rank_reg  <= '0;
			scrub_start_reg <= '0;
			scrub_end_reg   <= '0;
			io_dir_reg      <= 1'b0;
			fanout_reg      <= 1'b0;
			dir_agent_reg   <= '0;
		end
		else if (wr_stb)
		begin
			if (wb_adr_i == OFF_MIRROR_CFG)
			begin
				mir_mode_reg <= wb_dat_i[MIR_MODE_LSB +: 2];
				mir_tae_reg  <= wb_dat_i[MIR_TAE_BIT];
				mir_rspv_reg <= wb_dat_i[MIR_RSPV_BIT];
				mir_dir_reg  <= wb_dat_i[MIR_DIR_BIT];
				mir_trk_reg  <= wb_dat_i[MIR_TRK_LSB +: 2];
				mir_nid_reg  <= wb_dat_i[MIR_NID_LSB +: NID_W];
			end
			else if (wb_adr_i == OFF_CHAN_CTL)
				start_init_reg <= wb_dat_i[CH_START_BIT];
			else if (wb_adr_i == OFF_SPARE_CTL)
			begin
				spare_mode_reg <= wb_dat_i[SP_MODE_LSB +: 2];
				wp_dis_reg     <= wb_dat_i[SP_WPDIS_BIT];
				patrol_reg     <= wb_dat_i[SP_PATROL_BIT];
				smi_en_reg     <= wb_dat_i[SP_SMI_BIT];
				fail_rank_reg  <= wb_dat_i[SP_FAIL_LSB +: RANK_W];
				spare_rank_reg <= wb_dat_i[SP_SPARE_LSB +: RANK_W];
			end
			// pointers only load once patrol is off and the scrubber is idle
			else if (wb_adr_i == OFF_SCRUB_START && !patrol_reg && scrub_idle)
				scrub_start_reg <= wb_dat_i[ADDR_W-1:0];
			else if (wb_adr_i == OFF_SCRUB_END && !patrol_reg && scrub_idle)
				scrub_end_reg <= wb_dat_i[ADDR_W-1:0];
			else if (wb_adr_i == OFF_DIR_CFG)
			begin
				io_dir_reg    <= wb_dat_i[DIR_IOEN_BIT];
				fanout_reg    <= wb_dat_i[DIR_FANOUT_BIT];
				dir_agent_reg <= wb_dat_i[DIR_AGENT_LSB +: NID_W];
			end
		end
	end

	// read mux; unmapped offsets read zero
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			rdata_reg <= 32'h0000_0000;
		else if (!rd_stb)
			rdata_reg <= 32'h0000_0000;
		else if (wb_adr_i == OFF_MIRROR_CFG)
			rdata_reg <= 32'({mir_nid_reg, 1'b0, mir_trk_reg, mir_dir_reg, mir_rspv_reg, mir_tae_reg, mir_mode_reg});
		else if (wb_adr_i == OFF_CHAN_CTL)
			rdata_reg <= 32'({start_init_reg});
		else if (wb_adr_i == OFF_SPARE_CTL)
			rdata_reg <= 32'({spare_rank_reg, 1'b0, fail_rank_reg, 3'h0, smi_en_reg, patrol_reg, wp_dis_reg,
				spare_mode_reg});
		else if (wb_adr_i == OFF_SCRUB_START)
			rdata_reg <= 32'(scrub_start_reg);
		else if (wb_adr_i == OFF_SCRUB_END)
			rdata_reg <= 32'(scrub_end_reg);
		else if (wb_adr_i == OFF_STATUS)
			rdata_reg <= 32'({port_reg, 3'h0, snp_dup_reg, dir_err, conflict, scrub_idle, done_reg});
		else if (wb_adr_i == OFF_DIR_CFG)
			rdata_reg <= 32'({dir_agent_reg, 6'h00, fanout_reg, io_dir_reg});
		else if (wb_adr_i == OFF_INTERRUPTED)
			rdata_reg <= 32'(ptr_reg);
		else
			rdata_reg <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// mirror steering, registered from config so outputs stay glitch free
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			mirror_en       <= 1'b0;
			mirror_is_slave <= 1'b0;
			mirror_migrate  <= 1'b0;
			mirror_dest_nid <= '0;
			mirror_vn       <= VN_A1;
		end
		else
		begin
			mirror_en       <= (mir_mode_reg == MODE_MIRROR) || (mir_mode_reg == MODE_MIGRATE);
			mirror_is_slave <= mir_tae_reg;
			mirror_migrate  <= (mir_mode_reg == MODE_MIGRATE);
			mirror_dest_nid <= mir_nid_reg;
			mirror_vn       <= VN_A1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// init-done pin: three flops, level changes when stages two and three agree
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			sync_reg      <= 3'h0;
			init_done_reg <= 1'b0;
		end
		else
		begin
			sync_reg <= {sync_reg[1:0], phy_init_done};
			if (sync_reg[1] == sync_reg[2])
				init_done_reg <= sync_reg[2];
		end
	end

	// channel port state; reset is ignored while start_init is still set
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			port_reg <= PORT_READY;
		else if (wr_stb && wb_adr_i == OFF_CHAN_CTL && wb_dat_i[CH_RESET_BIT] && !start_init_reg)
			port_reg <= PORT_DISABLED;
		else
		begin
			case (port_reg)
				PORT_DISABLED:
					if (wr_stb && wb_adr_i == OFF_CHAN_CTL && wb_dat_i[CH_TRAIN_BIT])
						port_reg <= PORT_TRAINING;
				PORT_TRAINING:
					if (init_done_reg)
						port_reg <= PORT_READY;
				PORT_READY:
					if (start_init_reg)
						port_reg <= PORT_ACTIVE;
				PORT_ACTIVE:
					if (!start_init_reg)
						port_reg <= PORT_READY;
				default:
					port_reg <= PORT_READY;
			endcase
		end
	end

	// disabled port idles data lanes and parks clock lanes at DC high
	assign port_link_up     = (port_reg == PORT_ACTIVE);
	assign data_lane_idle   = (port_reg == PORT_DISABLED) || (port_reg == PORT_TRAINING);
	assign clk_lane_dc_high = (port_reg == PORT_DISABLED);
	assign phy_train_req    = (port_reg == PORT_TRAINING);
	assign write_post_en    = !wp_dis_reg;
	assign patrol_en        = patrol_reg;

	////////////////////////////////////////////////////////////////////////
	// sparing copy engine: start to end pointer, one line per copy handshake
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			copy_reg <= CP_IDLE;
			ptr_reg  <= '0;
		end
		else
		begin
			case (copy_reg)
				CP_IDLE:
					if (spare_mode_reg == SPARE_COPY && !conflict && scrub_idle)
					begin
						copy_reg <= CP_COPY;
						ptr_reg  <= scrub_start_reg;
					end
				CP_COPY:
					if (spare_mode_reg != SPARE_COPY)
						copy_reg <= CP_IDLE;
					else if (copy_ack && copy_last)
						copy_reg <= CP_DONE;
					else if (copy_ack)
						ptr_reg <= ptr_reg + 1'b1;
				CP_DONE:
					if (spare_mode_reg != SPARE_COPY)
						copy_reg <= CP_IDLE;
				default:
					copy_reg <= CP_IDLE;
			endcase
		end
	end

	assign copy_req      = (copy_reg == CP_COPY) && (spare_mode_reg == SPARE_COPY);
	assign copy_src_rank = fail_rank_reg;
	assign copy_dst_rank = spare_rank_reg;
	assign copy_addr     = ptr_reg;

	// done flag: completion wins over a same-cycle write-one-to-clear
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			done_reg <= 1'b0;
		else if (copy_finish)
			done_reg <= 1'b1;
		else if (wr_stb && wb_adr_i == OFF_STATUS && wb_dat_i[ST_DONE_BIT])
			done_reg <= 1'b0;
	end

	// management interrupt request, one pulse per completed copy
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			smi_req <= 1'b0;
		else
			smi_req <= copy_finish && smi_en_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// demand accesses: stall on the line being copied, mirror writes behind it
	assign acc_stall = acc_valid && copy_req && (acc_rank == fail_rank_reg) && (acc_addr == ptr_reg);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			acc_out_valid <= 1'b0;
			acc_out_write <= 1'b0;
			acc_out_rank  <= '0;
			acc_out_addr  <= '0;
			acc_out_dup   <= 1'b0;
		end
		else
		begin
			acc_out_valid <= acc_valid && !acc_stall;
			acc_out_write <= acc_write;
			acc_out_addr  <= acc_addr;
			// redirect sends all failing-rank traffic to the spare
			if (spare_mode_reg == SPARE_REDIRECT && acc_rank == fail_rank_reg)
				acc_out_rank <= spare_rank_reg;
			else
				acc_out_rank <= acc_rank;
			// writes to already copied lines also go to the spare, keeping it coherent
			acc_out_dup <= acc_valid && !acc_stall && acc_write && copy_req && (acc_rank == fail_rank_reg) &&
				(acc_addr >= scrub_start_reg) && (acc_addr < ptr_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// snoop responses: first from requester's hemisphere is taken, duplicates flagged
	assign snp_rsp_accept = snp_rsp_valid && !snp_seen_reg && !snp_txn_start &&
		(snp_rsp_nid[HEMI_BIT] == snp_req_nid[HEMI_BIT]);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			snp_seen_reg <= 1'b0;
		else if (snp_txn_start)
			snp_seen_reg <= 1'b0;
		else if (snp_rsp_accept)
			snp_seen_reg <= 1'b1;
	end

	// sticky duplicate/wrong-hemisphere flag; the event wins over a clear
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			snp_dup_reg <= 1'b0;
		else if (snp_rsp_valid && !snp_txn_start && !snp_rsp_accept)
			snp_dup_reg <= 1'b1;
		else if (wr_stb && wb_adr_i == OFF_STATUS && wb_dat_i[ST_SNPDUP_BIT])
			snp_dup_reg <= 1'b0;
	end

endmodule
`default_nettype wire

// >>> ras_ctrl_props.sv
// port assertions for the reliability control block
`timescale 1ns/1ps
`default_nettype none
module ras_ctrl_props
import ras_ctrl_pkg::*;
#(
	parameter int ADDR_W = 24
)
(
	input wire logic              clk_sys,
	input wire logic              nrst,
	input wire logic [1:0]        mirror_vn,
	input wire logic              port_link_up,
	input wire logic              data_lane_idle,
	input wire logic              clk_lane_dc_high,
	input wire logic              phy_train_req,
	input wire logic              write_post_en,
	input wire logic              patrol_en,
	input wire logic              smi_req,
	input wire logic              copy_req,
	input wire logic              copy_ack,
	input wire logic [ADDR_W-1:0] copy_addr,
	input wire logic              acc_valid,
	input wire logic [ADDR_W-1:0] acc_addr,
	input wire logic              acc_stall,
	input wire logic              acc_out_valid,
	input wire logic [ADDR_W-1:0] acc_out_addr,
	input wire logic              snp_txn_start,
	input wire logic [NID_W-1:0]  snp_req_nid,
	input wire logic              snp_rsp_valid,
	input wire logic [NID_W-1:0]  snp_rsp_nid,
	input wire logic              snp_rsp_accept
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////
	// mirror steering and channel port
	property p_vn; mirror_vn == VN_A1; endproperty
	a_vn: assert property (p_vn) else $error("mirror data left a network other than a1");
	property p_dc; clk_lane_dc_high |-> data_lane_idle && !port_link_up && !phy_train_req; endproperty
	a_dc: assert property (p_dc) else $error("disabled port lanes wrong");
	property p_link; port_link_up |-> !data_lane_idle && !clk_lane_dc_high; endproperty
	a_link: assert property (p_link) else $error("link up with lanes parked");
	////////////////////////////////////////////////////////////////////////
	// sparing copy engine, demand accesses and snoop responses
	property p_wp; copy_req |-> !write_post_en && !patrol_en; endproperty
	a_wp: assert property (p_wp) else $error("copy runs with posting or patrol on");
	property p_step; copy_req && copy_ack ##1 copy_req |-> copy_addr == ADDR_W'($past(copy_addr) + 1); endproperty
	a_step: assert property (p_step) else $error("copy pointer did not step by one");
	property p_hold; copy_req && !copy_ack ##1 copy_req |-> $stable(copy_addr); endproperty
	a_hold: assert property (p_hold) else $error("copy pointer moved without ack");
	property p_smi; smi_req |-> !copy_req && ($past(copy_ack) || $past(copy_ack, 2)); endproperty
	a_smi: assert property (p_smi) else $error("completion pulse without final ack");
	property p_stall; acc_stall |=> !acc_out_valid; endproperty
	a_stall: assert property (p_stall) else $error("stalled access was forwarded");
	property p_fwd; acc_valid && !acc_stall |=> acc_out_valid && acc_out_addr == $past(acc_addr); endproperty
	a_fwd: assert property (p_fwd) else $error("access lost or address changed");
	property p_snp;
		snp_rsp_accept |-> snp_rsp_valid && !snp_txn_start && snp_rsp_nid[HEMI_BIT] == snp_req_nid[HEMI_BIT];
	endproperty
	a_snp: assert property (p_snp) else $error("snoop response from wrong hemisphere taken");
	c_smi: cover property (smi_req);
	c_stall: cover property (acc_stall);
	c_snp: cover property (snp_rsp_accept);
endmodule
bind ras_ctrl ras_ctrl_props #(.ADDR_W(ADDR_W)) u_ras_ctrl_props (.*);
`default_nettype wire

// >>> mem_model.sv
// far side model: memory channel phy, scrubber and copy datapath
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic copy_req,
	input wire logic phy_train_req,
	input wire logic patrol_en,
	output logic     copy_ack,
	output logic     phy_init_done,
	output logic     scrub_idle,
	output int       acks
);
	logic [1:0] gap;
	logic [2:0] tcnt;
	////////////////////////////////////////////////////////////////////////
	// copy answers alternate prompt and slow; never two acks back to back, so no stray ack after the last line
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			copy_ack <= 1'b0;
			gap <= 2'h0;
			acks <= 0;
		end
		else
		begin
			copy_ack <= copy_req && !copy_ack && gap == 2'h0;
			gap <= copy_ack ? (acks[0] ? 2'h2 : 2'h0) : (gap != 2'h0 ? gap - 2'h1 : 2'h0);
			if (copy_req && copy_ack)
				acks <= acks + 1;
		end
	end
	// training finishes a few cycles after request; scrubber idles a cycle after patrol stops
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			tcnt <= 3'h0;
			phy_init_done <= 1'b0;
			scrub_idle <= 1'b1;
		end
		else
		begin
			tcnt <= phy_train_req ? tcnt + 3'(tcnt != 3'h7) : 3'h0;
			phy_init_done <= phy_train_req && tcnt >= 3'h3;
			scrub_idle <= !patrol_en;
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the reliability control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
import ras_ctrl_pkg::*;
	logic clk_sys = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_v;
	logic mirror_en, mirror_is_slave, mirror_migrate, phy_init_done, port_link_up, data_lane_idle;
	logic clk_lane_dc_high, phy_train_req, write_post_en, patrol_en, scrub_idle, smi_req, copy_req, copy_ack;
	logic [NID_W-1:0] mirror_dest_nid, snp_req_nid = 6'h00, snp_rsp_nid = 6'h00;
	logic [1:0] mirror_vn;
	logic [RANK_W-1:0] copy_src_rank, copy_dst_rank, acc_rank = 3'h0, acc_out_rank;
	logic [23:0] copy_addr, acc_addr = 24'h0, acc_out_addr;
	logic acc_valid = 1'b0, acc_write = 1'b0, acc_stall, acc_out_valid, acc_out_write, acc_out_dup;
	logic snp_txn_start = 1'b0, snp_rsp_valid = 1'b0, snp_rsp_accept;
	logic [31:0] mcfg [3] = '{32'h2A02, 32'h1506, 32'h2A01};
	logic [31:0] mexp [3] = '{32'h42A, 32'h615, 32'h52A};
	int fails = 0, checked = 0, acks, smis = 0, dups = 0, i;
	ras_ctrl u_ras_ctrl (.*);
	mem_model u_mem_model (.*);
	initial forever #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (smi_req === 1'b1) smis++;
	// writes mirrored onto the spare behind the copy pointer
	always @(posedge clk_sys) if (acc_out_dup === 1'b1 && acc_out_write === 1'b1) dups++;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle; ack latency is never assumed, only the watchdog ends a wait
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do
			@(posedge clk_sys);
		while (wb_ack_o !== 1'b1);
		rd_v = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, a, 32'h0);
			n++;
		end
		while ((rd_v & m) !== e && n < 40);
		chk(rd_v & m, e);
	endtask
	task automatic results;
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		results;
	end
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd_v, 32'h106);
		chk({30'h0, mirror_vn}, 32'h1);
		// master, slave, then migration pairing; slave keeps rsp vector and directory off, no traffic meanwhile
		for (i = 0; i < 3; i++)
		begin
			bus(1'b1, OFF_MIRROR_CFG, mcfg[i]);
			repeat (2) @(posedge clk_sys);
			chk({21'h0, mirror_en, mirror_is_slave, mirror_migrate, 2'h0, mirror_dest_nid}, mexp[i]);
		end
		// channel reset is refused while init start is set
		bus(1'b1, OFF_CHAN_CTL, 32'h1);
		repeat (3) @(posedge clk_sys);
		bus(1'b1, OFF_CHAN_CTL, 32'h3);
		repeat (2) @(posedge clk_sys);
		chk({29'h0, clk_lane_dc_high, data_lane_idle, port_link_up}, 32'h1);
		bus(1'b1, OFF_CHAN_CTL, 32'h0);
		bus(1'b1, OFF_CHAN_CTL, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk({29'h0, clk_lane_dc_high, data_lane_idle, port_link_up}, 32'h6);
		bus(1'b1, OFF_CHAN_CTL, 32'h4);
		poll(OFF_STATUS, 32'hF00, 32'h100);
		bus(1'b1, OFF_CHAN_CTL, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk({29'h0, clk_lane_dc_high, data_lane_idle, port_link_up}, 32'h1);
		// scrub pointers locked while patrol runs
		bus(1'b1, OFF_SPARE_CTL, 32'h8);
		bus(1'b1, OFF_SCRUB_START, 32'h55);
		bus(1'b0, OFF_SCRUB_START, 32'h0);
		chk(rd_v, 32'h0);
		bus(1'b1, OFF_SPARE_CTL, 32'h4);
		repeat (2) @(posedge clk_sys);
		chk({30'h0, write_post_en, patrol_en}, 32'h0);
		bus(1'b1, OFF_SCRUB_START, 32'h10);
		bus(1'b1, OFF_SCRUB_END, 32'h13);
		// copy held off while migration is still on; spare rank taken as like-organised
		bus(1'b1, OFF_SPARE_CTL, 32'h5215);
		repeat (4) @(posedge clk_sys);
		chk({31'h0, copy_req}, 32'h0);
		bus(1'b1, OFF_MIRROR_CFG, 32'h0);
		repeat (2) @(posedge clk_sys);
		// demand writes chase the copy pointer: stalls on the live line, one dup behind it
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk_sys);
			acc_valid <= 1'b1;
			acc_write <= 1'b1;
			acc_rank <= 3'h2;
			acc_addr <= copy_addr;
		end
		@(posedge clk_sys);
		acc_valid <= 1'b0;
		acc_write <= 1'b0;
		poll(OFF_STATUS, 32'h1, 32'h1);
		chk(acks, 32'h4);
		chk(smis, 32'h1);
		chk(dups, 32'h1);
		chk({26'h0, copy_src_rank, copy_dst_rank}, 32'h15);
		// redirect moves only the failing rank
		bus(1'b1, OFF_SPARE_CTL, 32'h5206);
		for (i = 2; i < 4; i++)
		begin
			@(posedge clk_sys);
			acc_valid <= 1'b1;
			acc_rank <= RANK_W'(i);
			acc_addr <= 24'h123;
			@(posedge clk_sys);
			acc_valid <= 1'b0;
			@(negedge clk_sys);
			chk({acc_out_valid, 4'h0, acc_out_rank, acc_out_addr}, {5'h10, (i == 2) ? 3'h5 : 3'h3, 24'h123});
		end
		// snoop: wrong hemisphere, right one, then a duplicate
		@(posedge clk_sys);
		snp_req_nid <= 6'h02;
		snp_txn_start <= 1'b1;
		@(posedge clk_sys);
		snp_txn_start <= 1'b0;
		snp_rsp_valid <= 1'b1;
		@(negedge clk_sys);
		chk({31'h0, snp_rsp_accept}, 32'h0);
		@(posedge clk_sys);
		snp_rsp_nid <= 6'h03;
		@(negedge clk_sys);
		chk({31'h0, snp_rsp_accept}, 32'h1);
		@(negedge clk_sys);
		chk({31'h0, snp_rsp_accept}, 32'h0);
		@(posedge clk_sys);
		snp_rsp_valid <= 1'b0;
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd_v & 32'h10, 32'h10);
		// both sticky flags clear on write-one
		bus(1'b1, OFF_STATUS, 32'h11);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd_v & 32'h11, 32'h0);
		// directory mode without fanout is reported
		bus(1'b1, OFF_DIR_CFG, 32'h0101);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(rd_v & 32'h8, 32'h8);
		bus(1'b0, 8'h20, 32'h0);
		chk(rd_v, 32'h0);
		results;
	end
endmodule
`default_nettype wire
